//--- coc_pkg.sv
// coc_pkg: register map, field layout, reset values and carrier types
// for the clock output configuration block.
// assumes: byte-wide registers reached through the serial port only.
package coc_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] COC_OFS_XO_HIGH = 8'h10;
  localparam logic [7:0] COC_OFS_XO_LOW = 8'h11;
  localparam logic [7:0] COC_OFS_OUT_EN = 8'h14;
  localparam logic [7:0] COC_OFS_OUT_POL = 8'h15;
  localparam logic [7:0] COC_OFS_DIV_UPPER = 8'h16;
  localparam logic [7:0] COC_OFS_DIV_LOWER = 8'h17;

  // ----------------------------------------------------------------
  // reset values and slew codes
  // ----------------------------------------------------------------
  localparam logic [1:0] COC_RST_XO_LOW_BITS = 2'h0;
  localparam logic [7:0] COC_RST_XO_HIGH_BITS = 8'h80;
  localparam logic [7:0] COC_RST_DIV_UPPER = 8'h00;
  localparam logic [7:0] COC_RST_DIV_LOWER = 8'h20;
  localparam logic [1:0] COC_SLEW_FAST = 2'h0;
  localparam logic [1:0] COC_SLEW_SLOW = 2'h2;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int COC_XO_LOW_MSB = 1;
  localparam int COC_BIT_TRISTATE0 = 2;
  localparam int COC_BIT_MUTE = 1;
  localparam int COC_BIT_INV1 = 5;
  localparam int COC_BIT_INV0 = 4;
  localparam int COC_SLEW_MSB = 7;
  localparam int COC_SLEW_LSB = 6;
  localparam int COC_BIT_PREDIV = 5;
  localparam int COC_BIT_DIV_MSB = 0;

  // ----------------------------------------------------------------
  // divider limits
  // ----------------------------------------------------------------
  localparam logic [8:0] COC_DIV_MIN = 9'h005;
  localparam logic [2:0] COC_PRE_LAST_DIV4 = 3'h3;
  localparam logic [2:0] COC_PRE_LAST_DIV5 = 3'h4;

  // ----------------------------------------------------------------
  // serial port
  // ----------------------------------------------------------------
  localparam logic [3:0] COC_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] COC_LAST_TX_BIT = 4'h7;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } coc_reg_req_t;

  typedef enum logic [3:0] {
    COC_ST_IDLE = 4'h0,
    COC_ST_ADDR = 4'h1,
    COC_ST_ADDR_ACK = 4'h2,
    COC_ST_PTR = 4'h3,
    COC_ST_PTR_ACK = 4'h4,
    COC_ST_WR = 4'h5,
    COC_ST_WR_ACK = 4'h6,
    COC_ST_RD = 4'h7,
    COC_ST_RD_ACK = 4'h8
  } coc_i2c_state_t;

endpackage : coc_pkg

//--- coc_i2c_slave.sv
// coc_i2c_slave: byte-oriented serial slave with register pointer,
// auto-increment on both writes and reads.
// assumes: scl and sda come from pins; the main block answers reads from
// rd_addr with registered data, well before the next byte is due.
`timescale 1ns/1ps
module coc_i2c_slave
  import coc_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h5a
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_b,
  output coc_reg_req_t req,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] scl_sync_r;
  logic [2:0] sda_sync_r;
  logic scl_r;
  logic sda_r;
  logic scl_prev_r;
  logic sda_prev_r;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[1:0], scl_in};
      sda_sync_r <= {sda_sync_r[1:0], sda_in};
    end
  end

  // a level only counts once stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end
    else
    begin
      if (scl_sync_r[1] == scl_sync_r[2])
        scl_r <= scl_sync_r[2];
      if (sda_sync_r[1] == sda_sync_r[2])
        sda_r <= sda_sync_r[2];
      scl_prev_r <= scl_r;
      sda_prev_r <= sda_r;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl_rise = scl_r && !scl_prev_r;
  assign scl_fall = !scl_r && scl_prev_r;
  assign start_cond = scl_r && scl_prev_r && !sda_r && sda_prev_r;
  assign stop_cond = scl_r && scl_prev_r && sda_r && !sda_prev_r;

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  coc_i2c_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [7:0] ptr_r;
  logic read_r;
  logic nack_r;

  assign rd_addr = ptr_r;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= COC_ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      read_r <= 1'b0;
      nack_r <= 1'b0;
      sda_oe_b <= 1'b1;
      req <= '0;
    end
    else
    begin
      req.wr <= 1'b0;
      if (stop_cond)
      begin
        state_r <= COC_ST_IDLE;
        sda_oe_b <= 1'b1;
      end
      else if (start_cond)
      begin
        state_r <= COC_ST_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe_b <= 1'b1;
      end
      else if (scl_rise)
      begin
        if (state_r == COC_ST_ADDR || state_r == COC_ST_PTR ||
            state_r == COC_ST_WR)
        begin
          shift_r <= {shift_r[6:0], sda_r};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        if (state_r == COC_ST_RD_ACK)
          nack_r <= sda_r;
      end
      else if (scl_fall)
      begin
        unique case (state_r)
          COC_ST_IDLE:
            sda_oe_b <= 1'b1;
          COC_ST_ADDR:
            if (bit_cnt_r == COC_BITS_PER_BYTE)
            begin
              if (shift_r[7:1] == SLAVE_ADDR)
              begin
                state_r <= COC_ST_ADDR_ACK;
                read_r <= shift_r[0];
                sda_oe_b <= 1'b0;
              end
              else
                state_r <= COC_ST_IDLE;
            end
          COC_ST_ADDR_ACK:
          begin
            bit_cnt_r <= 4'h0;
            if (read_r)
            begin
              state_r <= COC_ST_RD;
              tx_r <= rd_data;
              sda_oe_b <= rd_data[7];
            end
            else
            begin
              state_r <= COC_ST_PTR;
              sda_oe_b <= 1'b1;
            end
          end
          COC_ST_PTR:
            if (bit_cnt_r == COC_BITS_PER_BYTE)
            begin
              state_r <= COC_ST_PTR_ACK;
              ptr_r <= shift_r;
              sda_oe_b <= 1'b0;
            end
          COC_ST_PTR_ACK, COC_ST_WR_ACK:
          begin
            state_r <= COC_ST_WR;
            bit_cnt_r <= 4'h0;
            sda_oe_b <= 1'b1;
          end
          COC_ST_WR:
            if (bit_cnt_r == COC_BITS_PER_BYTE)
            begin
              state_r <= COC_ST_WR_ACK;
              req.wr <= 1'b1;
              req.addr <= ptr_r;
              req.data <= shift_r;
              ptr_r <= ptr_r + 8'h01;
              sda_oe_b <= 1'b0;
            end
          COC_ST_RD:
            if (bit_cnt_r == COC_LAST_TX_BIT)
            begin
              // release the line so the master can acknowledge
              state_r <= COC_ST_RD_ACK;
              ptr_r <= ptr_r + 8'h01;
              sda_oe_b <= 1'b1;
            end
            else
            begin
              tx_r <= {tx_r[6:0], 1'b0};
              sda_oe_b <= tx_r[6];
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          COC_ST_RD_ACK:
            if (nack_r)
              state_r <= COC_ST_IDLE;
            else
            begin
              state_r <= COC_ST_RD;
              bit_cnt_r <= 4'h0;
              tx_r <= rd_data;
              sda_oe_b <= rd_data[7];
            end
          default:
            state_r <= COC_ST_IDLE;
        endcase
      end
    end
  end

endmodule : coc_i2c_slave

//--- coc_clock_output_config.sv
// coc_clock_output_config: output stage configuration of a programmable
// oscillator - margining offset, output enables, polarity, slew, the
// 4/5 prescaler and the 9-bit channel divider behind a serial port.
// assumes: sys_clk stands in for the synthesiser clock feeding the
// output stage; sda is open drain with an external pull-up.
`timescale 1ns/1ps
module coc_clock_output_config
  import coc_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h5a
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_b,
  output logic first_clock_output,
  output logic first_clock_output_oe_b,
  output logic second_clock_output,
  output logic [1:0] edge_speed_select,
  output logic [9:0] crystal_margin_offset
);

  // ----------------------------------------------------------------
  // serial port
  // ----------------------------------------------------------------
  coc_reg_req_t req;
  logic [7:0] rd_addr;
  logic [7:0] rd_data_r;

  coc_i2c_slave #(
    .SLAVE_ADDR(SLAVE_ADDR)
  ) u_port (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe_b(sda_oe_b),
    .req(req),
    .rd_addr(rd_addr),
    .rd_data(rd_data_r)
  );

  // open drain: only ever pulls low
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      sda_out <= 1'b0;
    else
      sda_out <= 1'b0;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [1:0] xo_offset_high_r;
  logic [7:0] xo_offset_low_r;
  logic [7:0] out_en_r;
  logic [7:0] out_pol_r;
  logic [7:0] div_upper_r;
  logic [7:0] div_lower_r;
  logic [8:0] div_active_r;
  logic [8:0] div_nxt;

  logic wr_xo_high;
  logic wr_xo_low;
  logic wr_out_en;
  logic wr_out_pol;
  logic wr_div_upper;
  logic wr_div_lower;

  assign wr_xo_high = req.wr && (req.addr == COC_OFS_XO_HIGH);
  assign wr_xo_low = req.wr && (req.addr == COC_OFS_XO_LOW);
  assign wr_out_en = req.wr && (req.addr == COC_OFS_OUT_EN);
  assign wr_out_pol = req.wr && (req.addr == COC_OFS_OUT_POL);
  assign wr_div_upper = req.wr && (req.addr == COC_OFS_DIV_UPPER);
  assign wr_div_lower = req.wr && (req.addr == COC_OFS_DIV_LOWER);

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      xo_offset_high_r <= COC_RST_XO_LOW_BITS;
      xo_offset_low_r <= COC_RST_XO_HIGH_BITS;
    end
    else
    begin
      if (wr_xo_high)
        xo_offset_high_r <= req.data[COC_XO_LOW_MSB:0];
      if (wr_xo_low)
        xo_offset_low_r <= req.data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      out_en_r <= 8'h00;
    else if (wr_out_en)
    begin
      out_en_r <= 8'h00;
      out_en_r[COC_BIT_TRISTATE0] <= req.data[COC_BIT_TRISTATE0];
      out_en_r[COC_BIT_MUTE] <= req.data[COC_BIT_MUTE];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      out_pol_r <= 8'h00;
    else if (wr_out_pol)
    begin
      out_pol_r <= 8'h00;
      out_pol_r[COC_BIT_INV1] <= req.data[COC_BIT_INV1];
      out_pol_r[COC_BIT_INV0] <= req.data[COC_BIT_INV0];
    end
  end

  assign div_nxt = {req.data[COC_BIT_DIV_MSB], div_lower_r};

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_upper_r <= COC_RST_DIV_UPPER;
      div_lower_r <= COC_RST_DIV_LOWER;
    end
    else
    begin
      // the whole upper byte is writable, slew and prescaler included
      if (wr_div_upper)
        div_upper_r <= req.data;
      if (wr_div_lower)
        div_lower_r <= req.data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      div_active_r <= {COC_RST_DIV_UPPER[COC_BIT_DIV_MSB],
                       COC_RST_DIV_LOWER};
    else if (wr_div_upper && (div_nxt >= COC_DIV_MIN))
      // a reserved value would stall the channel, so the old one stays
      div_active_r <= div_nxt;
  end

  // ----------------------------------------------------------------
  // read-back
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_data_r <= 8'h00;
    else
    begin
      unique case (rd_addr)
        COC_OFS_XO_HIGH:
          rd_data_r <= {6'h00, xo_offset_high_r};
        COC_OFS_XO_LOW:
          rd_data_r <= xo_offset_low_r;
        COC_OFS_OUT_EN:
          rd_data_r <= out_en_r;
        COC_OFS_OUT_POL:
          rd_data_r <= out_pol_r;
        COC_OFS_DIV_UPPER:
          rd_data_r <= div_upper_r;
        COC_OFS_DIV_LOWER:
          rd_data_r <= div_lower_r;
        default:
          rd_data_r <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // prescaler and channel divider
  // ----------------------------------------------------------------
  logic [2:0] pre_cnt_r;
  logic [2:0] pre_last;
  logic pre_tick;
  logic [8:0] ch_cnt_r;
  logic [8:0] ch_half;
  logic base_clk_r;

  assign pre_last = div_upper_r[COC_BIT_PREDIV] ? COC_PRE_LAST_DIV5
                                                : COC_PRE_LAST_DIV4;
  assign pre_tick = (pre_cnt_r >= pre_last);

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      pre_cnt_r <= 3'h0;
    else if (pre_tick)
      pre_cnt_r <= 3'h0;
    else
      pre_cnt_r <= pre_cnt_r + 3'h1;
  end

  assign ch_half = (div_active_r >> 1) + 9'h001;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      ch_cnt_r <= 9'h000;
    else if (pre_tick)
    begin
      // >= covers a shrinking divide value without a long wrap
      if (ch_cnt_r >= div_active_r)
        ch_cnt_r <= 9'h000;
      else
        ch_cnt_r <= ch_cnt_r + 9'h001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      base_clk_r <= 1'b0;
    else
      base_clk_r <= (ch_cnt_r < ch_half);
  end

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  // mute holds low
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      first_clock_output <= 1'b0;
      second_clock_output <= 1'b0;
    end
    else if (out_en_r[COC_BIT_MUTE])
    begin
      first_clock_output <= 1'b0;
      second_clock_output <= 1'b0;
    end
    else
    begin
      first_clock_output <= base_clk_r ^ out_pol_r[COC_BIT_INV0];
      second_clock_output <= base_clk_r ^ out_pol_r[COC_BIT_INV1];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      first_clock_output_oe_b <= 1'b0;
    else
      first_clock_output_oe_b <= out_en_r[COC_BIT_TRISTATE0];
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      edge_speed_select <= COC_SLEW_FAST;
      crystal_margin_offset <= {COC_RST_XO_HIGH_BITS, COC_RST_XO_LOW_BITS};
    end
    else
    begin
      edge_speed_select <= div_upper_r[COC_SLEW_MSB:COC_SLEW_LSB];
      crystal_margin_offset <= {xo_offset_low_r, xo_offset_high_r};
    end
  end

endmodule : coc_clock_output_config

//--- coc_monitor.sv
// coc_monitor: port-level assertions for the clock output block.
// assumes: bound to coc_clock_output_config, one sys_clk domain.
`timescale 1ns/1ps
module coc_monitor
  import coc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_b,
  input wire logic first_clock_output,
  input wire logic first_clock_output_oe_b,
  input wire logic second_clock_output,
  input wire logic [1:0] edge_speed_select,
  input wire logic [9:0] crystal_margin_offset
);
  // longest legal phase is 1280 clocks, more than MAX_RUN; a mute holds a level for as long as it is set
  localparam int MAX_RUN = 1000;
  logic f0_q;
  logic f1_q;
  int run0_q;
  int run1_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // run length of each output level
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      f0_q <= 1'b0;
      f1_q <= 1'b0;
      run0_q <= 0;
      run1_q <= 0;
    end
    else
    begin
      f0_q <= first_clock_output;
      f1_q <= second_clock_output;
      run0_q <= (first_clock_output == f0_q) ? run0_q + 1 : 0;
      run1_q <= (second_clock_output == f1_q) ? run1_q + 1 : 0;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // a written byte lands while its acknowledge is being driven
  sequence s_ack_held;
    !sda_oe_b ##1 !sda_oe_b;
  endsequence

  property p_rst_offset;
    $rose(rst_b) |-> crystal_margin_offset == 10'h200;
  endproperty
  property p_rst_slew;
    $rose(rst_b) |-> edge_speed_select == COC_SLEW_FAST;
  endproperty
  property p_rst_drive;
    $rose(rst_b) |-> !first_clock_output_oe_b;
  endproperty
  property p_offset_on_ack;
    $changed(crystal_margin_offset) |-> s_ack_held;
  endproperty
  property p_slew_on_ack;
    $changed(edge_speed_select) |-> s_ack_held;
  endproperty
  property p_tri_on_ack;
    $changed(first_clock_output_oe_b) |-> s_ack_held;
  endproperty
  property p_first_runs;
    run0_q <= MAX_RUN;
  endproperty
  property p_second_runs;
    run1_q <= MAX_RUN;
  endproperty

  a_rst_offset: assert property (p_rst_offset)
    else $error("offset not mid-scale after reset");
  a_rst_slew: assert property (p_rst_slew)
    else $error("edge speed not fast after reset");
  a_rst_drive: assert property (p_rst_drive)
    else $error("first output not driven after reset");
  a_offset_on_ack: assert property (p_offset_on_ack)
    else $error("offset changed outside a register write");
  a_slew_on_ack: assert property (p_slew_on_ack)
    else $error("edge speed changed outside a register write");
  a_tri_on_ack: assert property (p_tri_on_ack)
    else $error("tri-state changed outside a register write");
  a_first_runs: assert property (p_first_runs)
    else $error("first output stopped toggling");
  a_second_runs: assert property (p_second_runs)
    else $error("second output stopped toggling");
endmodule : coc_monitor

bind coc_clock_output_config coc_monitor coc_monitor_i (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe_b(sda_oe_b),
  .first_clock_output(first_clock_output),
  .first_clock_output_oe_b(first_clock_output_oe_b),
  .second_clock_output(second_clock_output),
  .edge_speed_select(edge_speed_select),
  .crystal_margin_offset(crystal_margin_offset)
);

//--- coc_clk_sink.sv
// coc_clk_sink: downstream receiver that measures the delivered clock.
// assumes: the clock is slow against sys_clk, at least 4 clocks a phase.
`timescale 1ns/1ps
module coc_clk_sink
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_in,
  output int period,
  output int high,
  output int edges
);
  logic last_q;
  int cnt;
  int hcnt;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      last_q <= 1'b0;
      cnt <= 0;
      hcnt <= 0;
      period <= 0;
      high <= 0;
      edges <= 0;
    end
    else
    begin
      last_q <= clk_in;
      cnt <= cnt + 1;
      hcnt <= clk_in ? hcnt + 1 : hcnt;
      if (clk_in && !last_q)
      begin
        period <= cnt + 1;
        high <= hcnt;
        cnt <= 0;
        hcnt <= 1;
        edges <= edges + 1;
      end
    end
  end
endmodule : coc_clk_sink

//--- coc_clock_output_config_bench.sv
// coc_clock_output_config_bench: serial-port master driving the block.
// assumes: sda pull-up, modelled as a wired-and of master and slave.
`timescale 1ns/1ps
module coc_clock_output_config_bench
  import coc_pkg::*;
;
  localparam logic [6:0] SA = 7'h5a;
  localparam int LIMIT = 90000;
  localparam logic [7:0] RA [7] = '{8'h10, 8'h11, 8'h12, 8'h14, 8'h15,
    8'h16, 8'h17};
  localparam logic [7:0] RV [7] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h20};
  logic sys_clk, rst_b, scl_pin, sda_drv, sda_oe_b, sda_od, sda_line;
  logic first_clk, first_clk_oe_b, second_clk, acc, pre;
  logic [1:0] slew;
  logic [9:0] offset, v;
  logic [7:0] rd, pol;
  int period, high, edges, err_total, n_tests, cycles, seed, n;

  // the slave drives its data value only while enabled
  assign sda_line = sda_drv & (sda_oe_b | sda_od);

  coc_clock_output_config #(.SLAVE_ADDR(SA)) coc_clock_output_config_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .scl_in(scl_pin),
    .sda_in(sda_line), .sda_out(sda_od), .sda_oe_b(sda_oe_b),
    .first_clock_output(first_clk), .first_clock_output_oe_b(first_clk_oe_b),
    .second_clock_output(second_clk), .edge_speed_select(slew),
    .crystal_margin_offset(offset));
  coc_clk_sink coc_clk_sink_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .clk_in(first_clk), .period(period), .high(high), .edges(edges));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  function automatic int ticks(input int c, input logic p5);
    return c * (p5 ? 5 : 4);
  endfunction : ticks

  // waits two whole periods so a divider switch has settled
  task automatic per_chk(input int dv, input logic p5, input logic inv);
    int e;
    int p;
    int h;
    p = ticks(dv + 1, p5);
    h = ticks(dv / 2 + 1, p5);
    e = edges;
    for (int k = 0; k < 6000 && edges < e + 3; k++)
      cyc(1);
    chk("period", 16'(p), 16'(period));
    chk("high time", 16'(inv ? p - h : h), 16'(high));
  endtask : per_chk

  // stp 0 gives a (repeated) start, stp 1 a stop
  task automatic cond(input logic stp);
    cyc(4);
    sda_drv = ~stp;
    cyc(4);
    scl_pin = 1'b1;
    cyc(8);
    sda_drv = stp;
    cyc(8);
    scl_pin = stp;
  endtask : cond

  task automatic bit_io(input logic b, output logic r);
    cyc(4);
    sda_drv = b;
    cyc(4);
    scl_pin = 1'b1;
    cyc(8);
    r = sda_line;
    scl_pin = 1'b0;
  endtask : bit_io

  task automatic wbyte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
  endtask : wbyte

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    cond(1'b0);
    wbyte({SA, 1'b0});
    wbyte(a);
    wbyte(d);
    cond(1'b1);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    logic r;
    cond(1'b0);
    wbyte({SA, 1'b0});
    wbyte(a);
    cond(1'b0);
    wbyte({SA, 1'b1});
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
    cond(1'b1);
  endtask : reg_rd

  // ----------------------------------------------------------------
  // clock, timeout, main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      err_total++;
      $display("ERROR cycles expected below %0d seen %0d", LIMIT, cycles);
      conclude();
    end
  end

  initial
  begin
    seed = 32'h0000_6390;
    {err_total, n_tests} = '0;
    rst_b = 1'b0;
    scl_pin = 1'b1;
    sda_drv = 1'b1;
    cyc(2);
    rst_b = 1'b1;
    cyc(6);
    chk("offset", 16'h0200, 16'(offset));
    chk("slew", 16'(COC_SLEW_FAST), 16'(slew));
    chk("tristate", 16'h0000, 16'(first_clk_oe_b));
    for (int i = 0; i < 7; i++)
    begin
      reg_rd(RA[i], rd);
      chk("register", 16'(RV[i]), 16'(rd));
    end
    per_chk(32, 1'b0, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      v = (i == 0) ? 10'h3ff : 10'($random(seed));
      reg_wr(8'h11, v[9:2]);
      reg_wr(8'h10, {6'h3f, v[1:0]});
      chk("offset", 16'(v), 16'(offset));
    end
    reg_rd(8'h10, rd);
    chk("offset low", 16'(v[1:0]), 16'(rd));
    $display("test offset done");
    reg_wr(8'h14, 8'h04);
    chk("tristate", 16'h0001, 16'(first_clk_oe_b));
    reg_wr(8'h14, 8'h02);
    acc = 1'b0;
    repeat (200)
    begin
      cyc(1);
      acc = acc | first_clk | second_clk;
    end
    chk("muted", 16'h0000, 16'(acc));
    chk("tristate", 16'h0000, 16'(first_clk_oe_b));
    reg_wr(8'h14, 8'h00);
    $display("test enables done");
    for (int i = 0; i < 4; i++)
    begin
      pol = 8'(i << 4);
      reg_wr(8'h15, pol);
      per_chk(32, 1'b0, pol[4]);
      acc = 1'b0;
      repeat (40)
      begin
        cyc(1);
        acc = acc | (first_clk ^ second_clk ^ pol[4] ^ pol[5]);
      end
      chk("polarity", 16'h0000, 16'(acc));
    end
    reg_wr(8'h15, 8'h00);
    reg_wr(8'h16, 8'h80);
    chk("slew", 16'(COC_SLEW_SLOW), 16'(slew));
    reg_wr(8'h16, 8'h20);
    chk("slew", 16'(COC_SLEW_FAST), 16'(slew));
    per_chk(32, 1'b1, 1'b0);
    $display("test polarity and edges done");
    reg_wr(8'h17, 8'h05);
    reg_rd(8'h17, rd);
    chk("divider shadow", 16'h0005, 16'(rd));
    per_chk(32, 1'b1, 1'b0);
    reg_wr(8'h16, 8'h20);
    per_chk(5, 1'b1, 1'b0);
    // reserved divide value keeps the active ratio
    reg_wr(8'h17, 8'h03);
    reg_wr(8'h16, 8'h20);
    per_chk(5, 1'b1, 1'b0);
    reg_wr(8'h17, 8'hff);
    reg_wr(8'h16, 8'h00);
    per_chk(255, 1'b0, 1'b0);
    repeat (3)
    begin
      n = 5 + ({$random(seed)} % 251);
      pre = 1'($random(seed));
      reg_wr(8'h17, n[7:0]);
      reg_wr(8'h16, {2'h0, pre, 5'h00});
      per_chk(n, pre, 1'b0);
    end
    $display("test divider done");
    conclude();
  end
endmodule : coc_clock_output_config_bench
